//--- dv/dmx_ext_mem.sv
`timescale 1ns/100ps
// behavioural external data memory on the multiplexed address/data bus
module dmx_ext_mem
  import dmx_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire dmx_pkg::dmx_pins_t pins,
  output logic [7:0]              low_port_in,
  output int                      last_len,  // width of the last strobe in clocks
  output logic [15:0]             last_addr, // address caught at the last latch strobe
  output logic                    last_hi,   // high port was driven with that address
  output int                      bus_act    // cycles with a port driven or a read or write strobe active; the latch strobe is not counted
);
  logic [7:0] mem [int]; // only bytes that were written
  logic [7:0] wbyte;     // data seen on the low port during a write strobe
  logic       was_wr;    // the running strobe is a write
  logic [7:0] bus;       // what this device puts on the low port
  int         len;       // clocks of the running strobe
  assign low_port_in = bus;
  initial begin
    last_len = 0;
    bus_act = 0;
    len = 0;
    last_addr = 16'h0000;
    last_hi = 1'b0;
    bus = 8'h5A;
  end
  // latch the address, time the strobes, store writes at the trailing edge
  always @(posedge sys_clk) begin
    if (pins.low_port_oe || pins.high_port_oe || !pins.wr_n || !pins.rd_n) begin
      bus_act <= bus_act + 1;
    end
    // free-running latch strobes come without a driven port and are ignored
    if (pins.ale && pins.low_port_oe) begin
      last_addr <= {pins.high_port_oe ? pins.high_port_out : 8'h00, pins.low_port_out};
      last_hi <= pins.high_port_oe;
    end
    if (!pins.wr_n || !pins.rd_n) begin
      len <= len + 1;
      wbyte <= pins.low_port_out;
      was_wr <= !pins.wr_n;
    end else if (len != 0) begin
      last_len <= len;
      len <= 0;
      if (was_wr) begin
        mem[last_addr] = wbyte;
      end
    end
    // a released bus toggles every clock so a stale byte never passes as data
    if (!pins.rd_n) begin
      bus <= mem.exists(last_addr) ? mem[last_addr] : ~last_addr[7:0];
    end else begin
      bus <= ~bus;
    end
  end
endmodule

//--- dv/test_data_memory_onchip_expanded_ram_decoder.sv
`timescale 1ns/100ps
// self-checking bench: data spaces, expanded RAM, external bus and latch strobe
module test_data_memory_onchip_expanded_ram_decoder;
  import dmx_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b1;  // security strap: external bus selected after reset
  logic        double_speed_mode = 1'b0;
  logic        code_move_instruction = 1'b0;
  logic        int_req = 1'b0;
  logic        int_indirect = 1'b0;
  logic        int_write = 1'b0;
  logic [7:0]  int_addr = 8'h00;
  logic [7:0]  int_wdata = 8'h00;
  logic        stack_req = 1'b0;
  logic        stack_write = 1'b0;
  logic [7:0]  stack_addr = 8'h00;
  logic        stack_wrap_up = 1'b0;
  logic        stack_wrap_down = 1'b0;
  dmx_xreq_t   xreq = '0;
  logic [7:0]  int_rdata, xrdata, low_port_in;
  logic        sfr_sel, xbusy, xdone, last_hi;
  logic [15:0] last_addr;
  dmx_pins_t   pins;
  int          last_len, bus_act;
  int          mismatches = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h2244;
  logic [7:0]  xm [int];     // model of on-chip expanded RAM
  logic [7:0]  em [int];     // model of bytes written to the external memory
  int          sz [8] = '{256, 512, 768, 1024, 1792, 2048, 4096, 8192};
  logic [7:0]  aux = 8'h1E;  // bench copy of aux_memory_control
  logic [7:0]  aux1 = 8'h00; // bench copy of the pointer select / stack register
  logic [7:0]  r, d;
  logic        s;

  dmx_data_memory dmx_data_memory_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .hardware_security_byte(strap), .double_speed_mode(double_speed_mode),
    .code_move_instruction(code_move_instruction), .int_req(int_req), .int_indirect(int_indirect),
    .int_write(int_write), .int_addr(int_addr), .int_wdata(int_wdata), .int_rdata(int_rdata),
    .sfr_sel(sfr_sel), .stack_req(stack_req), .stack_write(stack_write), .stack_addr(stack_addr),
    .stack_wrap_up(stack_wrap_up), .stack_wrap_down(stack_wrap_down), .xreq(xreq), .xbusy(xbusy),
    .xdone(xdone), .xrdata(xrdata), .low_port_in(low_port_in), .pins(pins));
  dmx_ext_mem dmx_ext_mem_i (.sys_clk(sys_clk), .pins(pins), .low_port_in(low_port_in),
    .last_len(last_len), .last_addr(last_addr), .last_hi(last_hi), .bus_act(bus_act));

  // 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // hang guard: fewer than a thousand cycles are needed, the ceiling leaves wide room
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // one internal data access; read data and space select are combinational
  task automatic int_acc(input logic ind, input logic wr, input logic [7:0] a, input logic [7:0] wd,
                         output logic [7:0] rd, output logic sel);
    @(posedge sys_clk);
    int_req <= 1'b1;
    int_indirect <= ind;
    int_write <= wr;
    int_addr <= a;
    int_wdata <= wd;
    @(negedge sys_clk);
    rd = int_rdata;
    sel = sfr_sel;
    @(posedge sys_clk);
    int_req <= 1'b0;
    int_write <= 1'b0;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] rd;
    logic       sel;
    int_acc(1'b0, 1'b1, a, wd, rd, sel);
  endtask

  // load the chosen pointer; the stack top bit (bit 6) of the stack register is read-only, written as 0
  task automatic set_ptr(input logic sel, input logic [15:0] a);
    aux1[0] = sel;
    sfr_wr(DMX_AUX1_ADDR, aux1 & 8'h81);
    sfr_wr(sel ? DMX_PTR1_LO_ADDR : DMX_PTR0_LO_ADDR, a[7:0]);
    sfr_wr(sel ? DMX_PTR1_HI_ADDR : DMX_PTR0_HI_ADDR, a[15:8]);
  endtask

  // one external move, checked against the bench models
  task automatic move(input logic ptr, input logic wr, input logic [15:0] a);
    logic [7:0] wd, rd;
    logic       on;
    int         key, act, n;
    wd = rnd();
    key = ptr ? int'(a) : int'(a[7:0]);
    on = !aux[1] && (!ptr || a < sz[aux[4:2]]);
    if (ptr) set_ptr(seed[8], a);
    act = bus_act;
    @(posedge sys_clk);
    xreq <= '{1'b1, ptr, wr, a[7:0], wd};
    n = 0;
    while (xdone !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    rd = xrdata;
    chk("move done", 16'h0001, 16'(n < 200));
    @(posedge sys_clk);
    xreq.ext_move <= 1'b0;
    if (wr && on) xm[key] = wd;
    else if (wr) em[key] = wd;
    else chk("move data", on ? xm[key] : (em.exists(key) ? em[key] : ~a[7:0]), rd);
    if (on) chk("bus activity", act[15:0], bus_act[15:0]);
    else begin
      chk("strobe width", aux[5] ? 16'h001E : 16'h0006, last_len[15:0]);
      chk("bus address", key[15:0], last_addr);
      chk("high port used", {15'h0000, ptr}, {15'h0000, last_hi});
    end
  endtask

  // latch strobes in 60 clocks; a negative figure asks only for some
  task automatic ale_count(input int exp);
    int c;
    c = 0;
    repeat (8) @(posedge sys_clk);
    repeat (60) begin
      @(negedge sys_clk);
      if (pins.ale === 1'b1) c++;
    end
    @(posedge sys_clk);
    if (exp < 0) chk("latch strobes seen", 16'h0001, 16'(c != 0));
    else chk("latch strobes", exp[15:0], c[15:0]);
  endtask

  task automatic wrap(input logic up);
    @(posedge sys_clk);
    stack_wrap_up <= up;
    stack_wrap_down <= !up;
    @(posedge sys_clk);
    stack_wrap_up <= 1'b0;
    stack_wrap_down <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    int_acc(1'b0, 1'b0, DMX_AUX_CTRL_ADDR, 8'h00, r, s);
    chk("control reset", 16'h001E, {8'h00, r});
    int_acc(1'b0, 1'b0, DMX_AUX1_ADDR, 8'h00, r, s);
    chk("stack register reset", 16'h0000, {8'h00, r & 8'hC1});
    // lower region both ways, upper region apart from the sfr space
    d = rnd();
    int_acc(1'b0, 1'b1, 8'h30, d, r, s);
    int_acc(1'b1, 1'b0, 8'h30, 8'h00, r, s);
    chk("lower ram", {8'h00, d}, {8'h00, r});
    d = rnd();
    int_acc(1'b1, 1'b1, 8'hA5, d, r, s);
    chk("indirect select", 16'h0000, {15'h0000, s});
    int_acc(1'b0, 1'b1, 8'hA5, ~d, r, s);
    chk("direct select", 16'h0001, {15'h0000, s});
    int_acc(1'b1, 1'b0, 8'hA5, 8'h00, r, s);
    chk("upper ram", {8'h00, d}, {8'h00, r});
    ale_count(10);
    double_speed_mode <= 1'b1;
    ale_count(20);
    double_speed_mode <= 1'b0;
    // every size code: last visible byte stays on chip, the next one goes out
    for (int i = 0; i < 8; i++) begin
      aux = {2'b00, 1'b0, 3'(i), 2'b01};
      sfr_wr(DMX_AUX_CTRL_ADDR, aux);
      move(1'b1, 1'b1, 16'(sz[i] - 1));
      move(1'b1, 1'b0, 16'(sz[i] - 1));
      move(1'b1, 1'b1, 16'(sz[i]));
      move(1'b1, 1'b0, 16'(sz[i]));
    end
    ale_count(0);
    code_move_instruction <= 1'b1;
    ale_count(-1);
    code_move_instruction <= 1'b0;
    move(1'b0, 1'b1, 16'h00A0);
    move(1'b1, 1'b0, 16'h00A0);
    // stretched strobes on the external bus, both move forms
    aux = 8'h3E;
    sfr_wr(DMX_AUX_CTRL_ADDR, aux);
    move(1'b0, 1'b1, 16'h0055);
    move(1'b0, 1'b0, 16'h0055);
    move(1'b1, 1'b1, 16'h0123);
    move(1'b1, 1'b0, 16'h0123);
    // stack in the on-chip low page
    aux = 8'h1C;
    sfr_wr(DMX_AUX_CTRL_ADDR, aux);
    aux1 = 8'h80;
    sfr_wr(DMX_AUX1_ADDR, aux1);
    wrap(1'b1);
    int_acc(1'b0, 1'b0, DMX_AUX1_ADDR, 8'h00, r, s);
    chk("stack top set", 16'h00C0, {8'h00, r & 8'hC0});
    d = rnd();
    @(posedge sys_clk);
    stack_req <= 1'b1;
    stack_write <= 1'b1;
    stack_addr <= 8'h40;
    int_wdata <= d;
    @(posedge sys_clk);
    stack_req <= 1'b0;
    stack_write <= 1'b0;
    xm[16'h0040] = d;
    move(1'b1, 1'b0, 16'h0040);
    wrap(1'b0);
    int_acc(1'b0, 1'b0, DMX_AUX1_ADDR, 8'h00, r, s);
    chk("stack top clear", 16'h0080, {8'h00, r & 8'hC0});
    give_verdict();
  end
endmodule

//--- hw/dmx_data_memory.sv
`timescale 1ns/100ps
// Overview of operation
// - lower region 00-7F direct and indirect
// - upper RAM 80-FF indirect only
// - sfr space 80-FF direct only
// - above 7F, mode selects sfr or RAM
// - select clear: moves hit on-chip RAM
// - on-chip hits leave ports and strobes alone
// - pointer move beyond size uses external bus
// - above FF only via pointer form
// - register form: 8-bit address on low port
// - pointer form: 16-bit address on both ports
// - external move asserts write or read strobe
// - stack may live in on-chip RAM low page
// - strobe six or thirty clocks by stretch
// - size field picks visible on-chip RAM size
// - select loads from security byte after reset
// - latch strobe free-running unless suppressed
// - pointer select picks first or second pointer
// - stack top bit marks on-chip RAM stack
module dmx_data_memory
  import dmx_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            clk_en,
  input  wire logic            hardware_security_byte, // external select default
  input  wire logic            double_speed_mode,
  input  wire logic            code_move_instruction,  // code move active, wants latch strobe
  // internal data space access
  input  wire logic            int_req,
  input  wire logic            int_indirect,
  input  wire logic            int_write,
  input  wire logic [7:0]      int_addr,
  input  wire logic [7:0]      int_wdata,
  output logic [7:0]           int_rdata,
  output logic                 sfr_sel,                // direct access above 7F goes to sfr space
  // stack access
  input  wire logic            stack_req,
  input  wire logic            stack_write,
  input  wire logic [7:0]      stack_addr,
  input  wire logic            stack_wrap_up,          // stack pointer carried past FF
  input  wire logic            stack_wrap_down,        // stack pointer borrowed below 00
  // external move request
  input  wire dmx_pkg::dmx_xreq_t xreq,
  output logic                 xbusy,
  output logic                 xdone,
  output logic [7:0]           xrdata,
  // external bus pins
  input  wire logic [7:0]      low_port_in,
  output dmx_pkg::dmx_pins_t   pins
);
  import dmx_pkg::*;

  dmx_regs_t r;       // registered state
  dmx_regs_t next_r;  // next state

  logic [7:0] iram_lo [0:127];           // lower region
  logic [7:0] iram_hi [0:127];           // upper region, separate from sfr space
  logic [7:0] onchip_expanded_ram    [0:DMX_ONCHIP_EXPANDED_RAM_DEPTH-1];

  // visible on-chip RAM size in bytes for a size code
  function automatic logic [13:0] size_bytes(input logic [2:0] code);
    case (code)
      3'h0: size_bytes = 14'h0100;
      3'h1: size_bytes = 14'h0200;
      3'h2: size_bytes = 14'h0300;
      3'h3: size_bytes = 14'h0400;
      3'h4: size_bytes = 14'h0700;
      3'h5: size_bytes = 14'h0800;
      3'h6: size_bytes = 14'h1000;
      default: size_bytes = 14'h2000;
    endcase
  endfunction

  // aux control read value; bits 7,6 always read zero since they are not stored
  function automatic logic [7:0] aux_read(input dmx_regs_t s);
    aux_read = {2'h0, s.stretch, s.size_code, s.ext_sel, s.suppress};
  endfunction

  // request decode, shared by the state update and the storage writes
  logic [15:0] xaddr;
  logic        xhit_onchip;
  logic        int_upper;
  logic        sfr_write;
  logic [15:0] sel_ptr;
  logic [12:0] stack_xaddr;
  logic        xtake;        // external move accepted at this edge

  always_comb begin
    sel_ptr = r.psel ? r.ptr1 : r.ptr0;
    xaddr = xreq.use_pointer ? sel_ptr : {8'h00, xreq.reg_addr};
    // register form stays in the low page, so it can always hit when select is clear
    xhit_onchip = !r.ext_sel && ({2'h0, xaddr} < {4'h0, size_bytes(r.size_code)});
    int_upper = int_addr >= DMX_UPPER_BASE;
    sfr_write = int_req && int_write && !int_indirect && int_upper;
    stack_xaddr = {5'h00, stack_addr};
    // no take in the answer cycle, so a request held until xdone is not run twice
    xtake = r.state == DMX_IDLE && xreq.ext_move && !r.done;
  end

  assign sfr_sel = int_req && !int_indirect && int_upper;

  // internal read path; sfr reads return this block's own registers
  always_comb begin
    int_rdata = 8'h00;
    if (int_upper && !int_indirect) begin
      if (int_addr == DMX_AUX_CTRL_ADDR) begin
        int_rdata = aux_read(r);
      end else if (int_addr == DMX_AUX1_ADDR) begin
        int_rdata = {r.stack_ext, r.sp_top, 5'h00, r.psel};
      end else if (int_addr == DMX_PTR0_LO_ADDR) begin
        int_rdata = r.ptr0[7:0];
      end else if (int_addr == DMX_PTR0_HI_ADDR) begin
        int_rdata = r.ptr0[15:8];
      end else if (int_addr == DMX_PTR1_LO_ADDR) begin
        int_rdata = r.ptr1[7:0];
      end else if (int_addr == DMX_PTR1_HI_ADDR) begin
        int_rdata = r.ptr1[15:8];
      end else begin
        int_rdata = 8'h00;
      end
    end else if (int_upper) begin
      int_rdata = iram_hi[int_addr[6:0]];
    end else begin
      int_rdata = iram_lo[int_addr[6:0]];
    end
  end

  // storage writes: plain flip-flop arrays, addressed by index
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (int_req && int_write && !int_upper) begin
        iram_lo[int_addr[6:0]] <= int_wdata;
      end
      if (int_req && int_write && int_indirect && int_upper) begin
        iram_hi[int_addr[6:0]] <= int_wdata;
      end
      if (xtake && xreq.write && xhit_onchip) begin
        onchip_expanded_ram[xaddr[12:0]] <= xreq.wdata;
      end
      if (stack_req && stack_write && r.stack_ext && r.sp_top) begin
        onchip_expanded_ram[stack_xaddr] <= int_wdata;
      end
    end
  end

  // next-state logic: registers, bus sequencer and latch strobe
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    // the security strap is caught one clock after reset release
    if (!r.strap_done) begin
      next_r.ext_sel = hardware_security_byte;
      next_r.strap_done = 1'b1;
    end
    // sfr writes take effect from the following cycle
    if (sfr_write) begin
      if (int_addr == DMX_AUX_CTRL_ADDR) begin
        next_r.stretch = int_wdata[DMX_STRETCH_BIT];
        next_r.size_code = int_wdata[DMX_SIZE_LSB +: 3];
        next_r.ext_sel = int_wdata[DMX_EXTSEL_BIT];
        next_r.suppress = int_wdata[DMX_SUPPRESS_BIT];
      end else if (int_addr == DMX_AUX1_ADDR) begin
        next_r.stack_ext = int_wdata[DMX_STACKEXT_BIT];
        next_r.psel = int_wdata[DMX_PSEL_BIT];
      end else if (int_addr == DMX_PTR0_LO_ADDR) begin
        next_r.ptr0[7:0] = int_wdata;
      end else if (int_addr == DMX_PTR0_HI_ADDR) begin
        next_r.ptr0[15:8] = int_wdata;
      end else if (int_addr == DMX_PTR1_LO_ADDR) begin
        next_r.ptr1[7:0] = int_wdata;
      end else if (int_addr == DMX_PTR1_HI_ADDR) begin
        next_r.ptr1[15:8] = int_wdata;
      end
    end
    // stack top bit is hardware only, follows pointer carries
    if (!r.stack_ext) begin
      next_r.sp_top = 1'b0;
    end else if (stack_wrap_up) begin
      next_r.sp_top = ~r.sp_top;
    end else if (stack_wrap_down) begin
      next_r.sp_top = ~r.sp_top;
    end
    // external move sequencer
    case (r.state)
      DMX_IDLE: begin
        if (xtake) begin
          if (xhit_onchip) begin
            // on-chip hit: one-cycle answer, pins untouched
            next_r.rdata = onchip_expanded_ram[xaddr[12:0]];
            next_r.done = 1'b1;
          end else begin
            next_r.state = DMX_ADDR;
            next_r.busy = 1'b1;
            next_r.pins.low_port_out = xaddr[7:0];
            next_r.pins.low_port_oe = 1'b1;
            next_r.pins.high_port_oe = xreq.use_pointer;
            next_r.pins.high_port_out = xaddr[15:8];
            next_r.pins.ale = 1'b1;
          end
        end
      end
      DMX_ADDR: begin
        // address latched; data phase begins
        next_r.pins.ale = 1'b0;
        next_r.state = DMX_STROBE;
        next_r.cnt = r.stretch ? DMX_STROBE_LONG : DMX_STROBE_SHORT;
        next_r.pins.wr_n = !xreq.write;
        next_r.pins.rd_n = xreq.write;
        next_r.pins.low_port_out = xreq.wdata;
        next_r.pins.low_port_oe = xreq.write;
      end
      DMX_STROBE: begin
        if (r.cnt == 5'h01) begin
          next_r.state = DMX_DONE;
          next_r.pins.wr_n = 1'b1;
          next_r.pins.rd_n = 1'b1;
          next_r.rdata = low_port_in;
        end else begin
          next_r.cnt = r.cnt - 5'h01;
        end
      end
      default: begin
        next_r.state = DMX_IDLE;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.pins.low_port_oe = 1'b0;
        next_r.pins.high_port_oe = 1'b0;
      end
    endcase
    // free-running latch strobe when not suppressed and bus idle
    if (r.state == DMX_IDLE && !(xtake && !xhit_onchip)) begin
      if (!r.suppress) begin
        next_r.ale_cnt = (r.ale_cnt == 3'h1) ? (double_speed_mode ? DMX_ALE_DIV_X2 : DMX_ALE_DIV_STD)
                                             : r.ale_cnt - 3'h1;
        next_r.pins.ale = (r.ale_cnt == 3'h1);
      end else begin
        next_r.pins.ale = code_move_instruction;
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.state <= DMX_IDLE;
      r.stretch <= DMX_STRETCH_RST;
      r.size_code <= DMX_SIZE_RST;
      r.suppress <= DMX_SUPPRESS_RST;
      r.ale_cnt <= DMX_ALE_DIV_STD;
      r.pins.wr_n <= 1'b1;
      r.pins.rd_n <= 1'b1;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign pins   = r.pins;
  assign xbusy  = r.busy;
  assign xdone  = r.done;
  assign xrdata = r.rdata;

  property p_onchip_quiet;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && xtake && xhit_onchip) |=> (pins.wr_n && pins.rd_n && !xbusy && xdone);
  endproperty
  a_onchip_quiet: assert property (p_onchip_quiet) else $error("on-chip hit moved pins");

  property p_short_strobe;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && r.state == DMX_ADDR && !r.stretch && !xreq.write) |=> (!pins.rd_n) [*6] ##1 pins.rd_n;
  endproperty
  a_short_strobe: assert property (p_short_strobe) else $error("short strobe not six");

  property p_strobe_one;
    @(posedge sys_clk) disable iff (rst) !(!pins.wr_n && !pins.rd_n);
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("both strobes active");

  property p_ext_starts;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && xtake && r.ext_sel) |=> (xbusy && pins.low_port_oe);
  endproperty
  a_ext_starts: assert property (p_ext_starts) else $error("external move did not start");

  property p_ptr_high;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && xtake && !xhit_onchip && xreq.use_pointer)
        |=> (pins.high_port_oe && pins.high_port_out == $past(sel_ptr[15:8]));
  endproperty
  a_ptr_high: assert property (p_ptr_high) else $error("high byte wrong");

  property p_reg_form;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && xtake && !xhit_onchip && !xreq.use_pointer) |=> !pins.high_port_oe;
  endproperty
  a_reg_form: assert property (p_reg_form) else $error("register form drove high port");

  property p_sfr_direct;
    @(posedge sys_clk) disable iff (rst) (int_req && int_indirect) |-> !sfr_sel;
  endproperty
  a_sfr_direct: assert property (p_sfr_direct) else $error("indirect reached sfr");

  property p_sptop;
    @(posedge sys_clk) disable iff (rst) (clk_en && !r.stack_ext) |=> !r.sp_top;
  endproperty
  a_sptop: assert property (p_sptop) else $error("stack top bit set without extension");

  property p_indirect_no_sfr;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && int_req && int_write && int_indirect)
        |=> (r.stretch == $past(r.stretch) && r.size_code == $past(r.size_code)
             && r.suppress == $past(r.suppress) && r.psel == $past(r.psel)
             && r.ptr0 == $past(r.ptr0) && r.ptr1 == $past(r.ptr1));
  endproperty
  a_indirect_no_sfr: assert property (p_indirect_no_sfr) else $error("indirect write reached sfr");

  property p_long_strobe;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && r.state == DMX_ADDR && r.stretch)
        |=> !(pins.wr_n && pins.rd_n) ##29 !(pins.wr_n && pins.rd_n) ##1 (pins.wr_n && pins.rd_n);
  endproperty
  a_long_strobe: assert property (p_long_strobe) else $error("long strobe not thirty");

  property p_onchip_ports;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && xtake && xhit_onchip)
        |=> (!pins.low_port_oe && !pins.high_port_oe && pins.low_port_out == $past(pins.low_port_out)
             && pins.high_port_out == $past(pins.high_port_out));
  endproperty
  a_onchip_ports: assert property (p_onchip_ports) else $error("on-chip hit drove a port");

  property p_strap;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && !r.strap_done && !sfr_write) |=> (r.ext_sel == $past(hardware_security_byte));
  endproperty
  a_strap: assert property (p_strap) else $error("select not loaded from strap");

  property p_done_pulse;
    @(posedge sys_clk) disable iff (rst) (clk_en && xdone) |=> !xdone;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("move answered twice");

  property p_sp_wrap;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && r.stack_ext && (stack_wrap_up || stack_wrap_down)) |=> (r.sp_top != $past(r.sp_top));
  endproperty
  a_sp_wrap: assert property (p_sp_wrap) else $error("stack top bit missed a wrap");
endmodule

//--- inc/dmx_pkg.sv
package dmx_pkg;
  // sfr addresses that this block owns
  localparam logic [7:0] DMX_AUX_CTRL_ADDR   = 8'h8E;  // aux_memory_control
  localparam logic [7:0] DMX_AUX1_ADDR       = 8'hA2;  // pointer select / stack register
  localparam logic [7:0] DMX_PTR0_LO_ADDR    = 8'h82;
  localparam logic [7:0] DMX_PTR0_HI_ADDR    = 8'h83;
  localparam logic [7:0] DMX_PTR1_LO_ADDR    = 8'h84;
  localparam logic [7:0] DMX_PTR1_HI_ADDR    = 8'h85;
  localparam logic [7:0] DMX_UPPER_BASE      = 8'h80;  // first address above the lower region
  // aux_memory_control field positions
  localparam int DMX_STRETCH_BIT  = 5;
  localparam int DMX_SIZE_LSB     = 2;
  localparam int DMX_EXTSEL_BIT   = 1;
  localparam int DMX_SUPPRESS_BIT = 0;
  // aux register 1 field positions
  localparam int DMX_STACKEXT_BIT = 7;
  localparam int DMX_SPTOP_BIT    = 6;
  localparam int DMX_PSEL_BIT     = 0;
  // reset values (external select comes from the security byte)
  localparam logic       DMX_STRETCH_RST  = 1'b0;
  localparam logic [2:0] DMX_SIZE_RST     = 3'h7;
  localparam logic       DMX_SUPPRESS_RST = 1'b0;
  // strobe widths in clock periods
  localparam logic [4:0] DMX_STROBE_SHORT = 5'h06;
  localparam logic [4:0] DMX_STROBE_LONG  = 5'h1E;
  // latch strobe periods: one sixth, or one third in double speed
  localparam logic [2:0] DMX_ALE_DIV_STD  = 3'h6;
  localparam logic [2:0] DMX_ALE_DIV_X2   = 3'h3;
  localparam int         DMX_ONCHIP_EXPANDED_RAM_DEPTH   = 8192;

  typedef enum logic [1:0] {DMX_IDLE, DMX_ADDR, DMX_STROBE, DMX_DONE} dmx_state_t;

  // core request toward the data memory unit
  typedef struct packed {
    logic        ext_move;    // external move instruction
    logic        use_pointer; // 16-bit pointer form
    logic        write;
    logic [7:0]  reg_addr;    // register-indirect address
    logic [7:0]  wdata;
  } dmx_xreq_t;

  // external bus pins
  typedef struct packed {
    logic [7:0] low_port_out;
    logic       low_port_oe;
    logic [7:0] high_port_out;
    logic       high_port_oe;
    logic       wr_n;
    logic       rd_n;
    logic       ale;
  } dmx_pins_t;

  // full module state
  typedef struct packed {
    dmx_state_t  state;
    logic        stretch;
    logic [2:0]  size_code;
    logic        ext_sel;
    logic        suppress;
    logic        stack_ext;
    logic        sp_top;
    logic        psel;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [4:0]  cnt;
    logic [2:0]  ale_cnt;
    logic        strap_done;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    dmx_pins_t   pins;
  } dmx_regs_t;
endpackage
